// *** rtl/rtrf_pkg.sv ***
// shared constants for the remote temperature result filter block
package rtrf_pkg;

	// ----------------------------------------------------------------
	// register offsets on the device register port
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_LOCAL_HI   = 8'h00; // local integer byte
	localparam logic [7:0] ADDR_REMOTE_HI  = 8'h01; // remote integer byte
	localparam logic [7:0] ADDR_STATUS     = 8'h02; // status flags
	localparam logic [7:0] ADDR_REMOTE_LO  = 8'h10; // remote fraction byte
	localparam logic [7:0] ADDR_LOCAL_LO   = 8'h15; // local fraction byte
	localparam logic [7:0] ADDR_FILT_CTRL  = 8'h24; // averaging control

	// ----------------------------------------------------------------
	// averaging control encodings and reset value
	// ----------------------------------------------------------------
	localparam logic [7:0] FILT_OFF        = 8'h00; // pass samples through
	localparam logic [7:0] FILT_AVG4       = 8'h01; // mean of four samples
	localparam logic [7:0] FILT_AVG8       = 8'h02; // mean of eight samples
	localparam logic [7:0] FILT_CTRL_RST   = 8'h00; // filter off after reset

	// ----------------------------------------------------------------
	// status register layout
	// ----------------------------------------------------------------
	localparam int         STATUS_OPEN_BIT = 2;     // diode disconnect flag
	localparam logic [7:0] STATUS_RST      = 8'h00;

	// ----------------------------------------------------------------
	// temperature code: signed, 1/16 degree per count
	// ----------------------------------------------------------------
	localparam int                 TEMP_W      = 13;
	localparam int                 HIST_DEPTH  = 8;
	localparam logic signed [12:0] TEMP_MIN    = 13'sh1C00; // -64 degrees
	localparam logic signed [12:0] TEMP_MAX_STD = 13'sh07FF; // 127.9375
	localparam logic signed [12:0] TEMP_MAX_EXT = 13'sh0BFF; // 191.9375
	localparam logic signed [12:0] EXT_OFFSET  = 13'sh0400; // +64 degrees
	localparam logic signed [12:0] SHORT_CODE  = 13'sh1C00; // shorted diode
	localparam logic        [3:0]  FRAC_PAD    = 4'h0;      // unused bits

endpackage : rtrf_pkg

// *** rtl/rtrf_avg.sv ***
// moving-average filter for the remote temperature samples
`timescale 1ns/1ps
module rtrf_avg
(
	// clock and reset
	input  wire  logic               clk,
	input  wire  logic               nrst,
	// raw remote samples
	input  wire  logic               samp_valid,
	input  wire  logic signed [12:0] samp,
	// averaging control register value
	input  wire  logic        [7:0]  mode,
	// filtered output
	output logic                     avg_valid,
	output logic signed       [12:0] avg
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int HIST_DEPTH = rtrf_pkg::HIST_DEPTH;

	logic signed [12:0] hist_reg  [HIST_DEPTH]; // newest sample at 0
	logic signed [12:0] hist_next [HIST_DEPTH];
	logic        [7:0]  mode_reg;               // mode of last sample
	logic        [7:0]  mode_next;
	logic               avg_valid_reg;
	logic               avg_valid_next;
	logic signed [12:0] avg_reg;
	logic signed [12:0] avg_next;
	logic signed [15:0] sum4;                   // sum of newest four
	logic signed [15:0] sum8;                   // sum of all eight

	// ----------------------------------------------------------------
	// history, sums and output selection
	// ----------------------------------------------------------------
	// a mode change refills the whole history with the new sample, so
	// the first average after enabling is not dragged toward stale data
	always_comb
	begin
		hist_next      = hist_reg;
		mode_next      = mode_reg;
		avg_valid_next = samp_valid;
		avg_next       = avg_reg;
		sum4           = 16'sh0000;
		sum8           = 16'sh0000;
		if (samp_valid)
		begin
			mode_next = mode;
			for (int i = 0; i < HIST_DEPTH; i++)
			begin
				if (mode != mode_reg)
					hist_next[i] = samp;
				else if (i == 0)
					hist_next[i] = samp;
				else
					hist_next[i] = hist_reg[i-1];
			end
		end
		for (int i = 0; i < HIST_DEPTH; i++)
		begin
			if (i < 4)
				sum4 = sum4 + 16'(hist_next[i]);
			sum8 = sum8 + 16'(hist_next[i]);
		end
		if (samp_valid)
		begin
			case (mode)
				rtrf_pkg::FILT_AVG4: avg_next = 13'(sum4 >>> 2);
				rtrf_pkg::FILT_AVG8: avg_next = 13'(sum8 >>> 3);
				default:             avg_next = samp;
			endcase
		end
	end

	// registers only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_reg[i] <= 13'sh0000;
			mode_reg      <= rtrf_pkg::FILT_CTRL_RST;
			avg_valid_reg <= 1'b0;
			avg_reg       <= 13'sh0000;
		end
		else
		begin
			hist_reg      <= hist_next;
			mode_reg      <= mode_next;
			avg_valid_reg <= avg_valid_next;
			avg_reg       <= avg_next;
		end
	end

	assign avg_valid = avg_valid_reg;
	assign avg       = avg_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_avg4_mean: assert property (samp_valid
		&& mode == rtrf_pkg::FILT_AVG4
		|=> avg == 13'((16'(hist_reg[0]) + 16'(hist_reg[1])
		+ 16'(hist_reg[2]) + 16'(hist_reg[3])) >>> 2))
		else $error("four-sample mean wrong");

	// the history seen one cycle later is the one the mean was taken on
	a_avg8_mean: assert property (samp_valid
		&& mode == rtrf_pkg::FILT_AVG8
		|=> avg == 13'((16'(hist_reg[0]) + 16'(hist_reg[1])
		+ 16'(hist_reg[2]) + 16'(hist_reg[3]) + 16'(hist_reg[4])
		+ 16'(hist_reg[5]) + 16'(hist_reg[6])
		+ 16'(hist_reg[7])) >>> 3))
		else $error("eight-sample mean wrong");

	a_bypass_pass: assert property (samp_valid
		&& mode == rtrf_pkg::FILT_OFF
		|=> avg_valid && avg == $past(samp))
		else $error("disabled filter altered sample");

endmodule : rtrf_avg

// *** rtl/rtrf_top.sv ***
// result formatting, remote averaging and diode fault flag
`timescale 1ns/1ps
module rtrf_top
(
	// clock and reset
	input  wire  logic               clk,
	input  wire  logic               nrst,
	// register port from the serial slave
	input  wire  logic               reg_wr_en,
	input  wire  logic               reg_rd_en,
	input  wire  logic        [7:0]  reg_addr,
	input  wire  logic        [7:0]  reg_wdata,
	output logic              [7:0]  reg_rdata,
	// conversion engine
	input  wire  logic               range_ext,
	input  wire  logic               conv_busy,
	input  wire  logic               local_valid,
	input  wire  logic signed [12:0] local_temp,
	input  wire  logic               remote_valid,
	input  wire  logic signed [12:0] remote_temp,
	// diode fault comparator pins, asynchronous
	input  wire  logic               diode_fault_pin,
	input  wire  logic               diode_short_pin,
	// over-temperature limit and results
	input  wire  logic        [7:0]  overtemp_limit,
	output logic                     diode_open_flag,
	output logic                     overtemp_trip_output
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic               fault_meta_reg, fault_sync_reg; // fault synchroniser
	logic               short_meta_reg, short_sync_reg; // short synchroniser
	logic        [7:0]  filt_ctrl_reg,  filt_ctrl_next; // averaging control
	logic               open_reg,       open_next;      // disconnect flag
	logic               fseen_reg,      fseen_next;     // fault this conv
	logic        [7:0]  rem_hi_reg,     rem_hi_next;
	logic        [7:0]  rem_lo_reg,     rem_lo_next;
	logic        [7:0]  loc_hi_reg,     loc_hi_next;
	logic        [7:0]  loc_lo_reg,     loc_lo_next;
	logic               trip_reg,       trip_next;
	logic        [7:0]  rdata_reg,      rdata_next;
	logic               ctrl_wr_reg,    ctrl_wr_next;   // helper for checks
	logic signed [12:0] rem_samp;                       // after short check
	logic               avg_valid;
	logic signed [12:0] avg;
	logic        [15:0] rem_fmt;
	logic        [15:0] loc_fmt;

	// ----------------------------------------------------------------
	// formatting: integer byte high, fraction nibble on top of low byte
	// ----------------------------------------------------------------
	function automatic logic [15:0] fmt(input logic signed [12:0] t,
		input logic ext);
		logic signed [12:0] c;
		c = (t < rtrf_pkg::TEMP_MIN) ? rtrf_pkg::TEMP_MIN : t;
		if (ext)
		begin
			if (c > rtrf_pkg::TEMP_MAX_EXT)
				c = rtrf_pkg::TEMP_MAX_EXT;
			c = 13'(c + rtrf_pkg::EXT_OFFSET);
		end
		else if (c > rtrf_pkg::TEMP_MAX_STD)
			c = rtrf_pkg::TEMP_MAX_STD;
		// standard codes keep their sign bits: twos complement byte
		fmt = {c[11:4], c[3:0], rtrf_pkg::FRAC_PAD};
	endfunction : fmt

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two stages each; only the second stage is read by logic
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fault_meta_reg <= 1'b0;
			fault_sync_reg <= 1'b0;
			short_meta_reg <= 1'b0;
			short_sync_reg <= 1'b0;
		end
		else
		begin
			fault_meta_reg <= diode_fault_pin;
			fault_sync_reg <= fault_meta_reg;
			short_meta_reg <= diode_short_pin;
			short_sync_reg <= short_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// remote averaging filter, remote channel only
	// ----------------------------------------------------------------
	// a shorted diode replaces the sample with the -64 degree code
	assign rem_samp = short_sync_reg ? rtrf_pkg::SHORT_CODE
		: remote_temp;

	rtrf_avg rtrf_avg_inst
	(
		.clk        (clk),
		.nrst       (nrst),
		.samp_valid (remote_valid),
		.samp       (rem_samp),
		.mode       (filt_ctrl_reg),
		.avg_valid  (avg_valid),
		.avg        (avg)
	);

	assign rem_fmt = fmt(avg, range_ext);
	assign loc_fmt = fmt(local_temp, range_ext);

	// ----------------------------------------------------------------
	// next-state logic for results, flags and register port
	// ----------------------------------------------------------------
	always_comb
	begin
		filt_ctrl_next = filt_ctrl_reg;
		open_next      = open_reg;
		fseen_next     = fseen_reg;
		rem_hi_next    = rem_hi_reg;
		rem_lo_next    = rem_lo_reg;
		loc_hi_next    = loc_hi_reg;
		loc_lo_next    = loc_lo_reg;
		trip_next      = trip_reg;
		rdata_next     = rdata_reg;
		ctrl_wr_next   = ctrl_wr_reg || (reg_wr_en
			&& reg_addr == rtrf_pkg::ADDR_FILT_CTRL);
		// control write; other addresses are owned elsewhere
		if (reg_wr_en && reg_addr == rtrf_pkg::ADDR_FILT_CTRL)
			filt_ctrl_next = reg_wdata;
		// comparator sampled on every cycle of a conversion
		if (conv_busy && fault_sync_reg)
			fseen_next = 1'b1;
		// conversion end: publish fault state, arm for next conversion
		if (remote_valid)
		begin
			open_next  = fseen_reg || fault_sync_reg;
			fseen_next = 1'b0;
		end
		// filtered remote result and limit compare use the same value
		if (avg_valid)
		begin
			rem_hi_next = rem_fmt[15:8];
			rem_lo_next = rem_fmt[7:0];
			if (range_ext)
				trip_next = rem_fmt[15:8] > overtemp_limit;
			else
				trip_next = $signed(rem_fmt[15:8])
					> $signed(overtemp_limit);
		end
		// local channel never passes through the filter
		if (local_valid)
		begin
			loc_hi_next = loc_fmt[15:8];
			loc_lo_next = loc_fmt[7:0];
		end
		// read data captured on the read strobe, held otherwise
		if (reg_rd_en)
		begin
			case (reg_addr)
				rtrf_pkg::ADDR_LOCAL_HI:  rdata_next = loc_hi_reg;
				rtrf_pkg::ADDR_LOCAL_LO:  rdata_next = loc_lo_reg;
				rtrf_pkg::ADDR_REMOTE_HI: rdata_next = rem_hi_reg;
				rtrf_pkg::ADDR_REMOTE_LO: rdata_next = rem_lo_reg;
				rtrf_pkg::ADDR_STATUS:    rdata_next = rtrf_pkg::STATUS_RST
					| 8'({7'h00, open_reg} << rtrf_pkg::STATUS_OPEN_BIT);
				rtrf_pkg::ADDR_FILT_CTRL: rdata_next = filt_ctrl_reg;
				default:                  rdata_next = 8'h00;
			endcase
		end
	end

	// registers only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			filt_ctrl_reg <= rtrf_pkg::FILT_CTRL_RST;
			open_reg      <= 1'b0;
			fseen_reg     <= 1'b0;
			rem_hi_reg    <= 8'h00;
			rem_lo_reg    <= 8'h00;
			loc_hi_reg    <= 8'h00;
			loc_lo_reg    <= 8'h00;
			trip_reg      <= 1'b0;
			rdata_reg     <= 8'h00;
			ctrl_wr_reg   <= 1'b0;
		end
		else
		begin
			filt_ctrl_reg <= filt_ctrl_next;
			open_reg      <= open_next;
			fseen_reg     <= fseen_next;
			rem_hi_reg    <= rem_hi_next;
			rem_lo_reg    <= rem_lo_next;
			loc_hi_reg    <= loc_hi_next;
			loc_lo_reg    <= loc_lo_next;
			trip_reg      <= trip_next;
			rdata_reg     <= rdata_next;
			ctrl_wr_reg   <= ctrl_wr_next;
		end
	end

	assign reg_rdata            = rdata_reg;
	assign diode_open_flag      = open_reg;
	assign overtemp_trip_output = trip_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_short_sample;
		remote_valid && short_sync_reg && !range_ext
			&& filt_ctrl_reg == rtrf_pkg::FILT_OFF;
	endsequence

	sequence s_result_load;
		##1 avg_valid && !range_ext ##1 1'b1;
	endsequence

	a_frac_low_zero: assert property (rem_lo_reg[3:0] == 4'h0
		&& loc_lo_reg[3:0] == 4'h0)
		else $error("fraction low bits not zero");

	a_std_hi_int: assert property (avg_valid && !range_ext
		&& avg <= rtrf_pkg::TEMP_MAX_STD && avg >= rtrf_pkg::TEMP_MIN
		|=> rem_hi_reg == $past(avg[11:4]))
		else $error("standard integer byte wrong");

	a_std_negative: assert property (avg_valid && !range_ext
		&& avg < 0 |=> rem_hi_reg[7])
		else $error("negative value lost its sign");

	a_local_unfilt: assert property (local_valid && !range_ext
		&& local_temp <= rtrf_pkg::TEMP_MAX_STD
		&& local_temp >= rtrf_pkg::TEMP_MIN
		|=> loc_hi_reg == $past(local_temp[11:4]))
		else $error("local result not taken directly");

	a_result_load: assert property (avg_valid
		|=> rem_hi_reg == $past(rem_fmt[15:8])
		&& rem_lo_reg == $past(rem_fmt[7:0]))
		else $error("remote result not loaded from filter");

	a_trip_filtered: assert property (avg_valid && range_ext
		|=> overtemp_trip_output == (rem_hi_reg > $past(overtemp_limit)))
		else $error("limit compare not on filtered value");

	a_reset_off: assert property (!ctrl_wr_reg
		|-> filt_ctrl_reg == rtrf_pkg::FILT_OFF)
		else $error("averaging enabled without a write");

	a_short_minus64: assert property (s_short_sample
		|-> s_result_load ##0 rem_hi_reg == 8'hC0)
		else $error("shorted diode not reported as -64");

	a_fault_pending: assert property (conv_busy && fault_sync_reg
		&& !remote_valid |=> fseen_reg)
		else $error("fault during conversion missed");

	a_fault_publish: assert property (remote_valid && fseen_reg
		|=> diode_open_flag)
		else $error("pending fault not published");

	a_open_flag: assert property (reg_rd_en
		&& reg_addr == rtrf_pkg::ADDR_STATUS
		|=> reg_rdata[2] == $past(diode_open_flag))
		else $error("disconnect flag not at bit 2");

	a_ext_offset: assert property (avg_valid && range_ext
		&& avg >= rtrf_pkg::TEMP_MIN && avg <= rtrf_pkg::TEMP_MAX_EXT
		|=> rem_hi_reg == $past(8'(13'(avg + rtrf_pkg::EXT_OFFSET) >> 4)))
		else $error("extended offset wrong");

	a_std_saturate: assert property (avg_valid && !range_ext
		&& avg > rtrf_pkg::TEMP_MAX_STD
		|=> {rem_hi_reg, rem_lo_reg[7:4]} == 12'h7FF)
		else $error("standard range not saturated");

endmodule : rtrf_top

// *** verification/rtrf_diode_model.sv ***
// behavioural remote diode and conversion engine facing the block
`timescale 1ns/1ps
module rtrf_diode_model
(
	// clock and reset
	input  wire  logic               clk,
	input  wire  logic               nrst,
	// conversion command from the bench
	input  wire  logic               start,
	input  wire  logic signed [12:0] temp_in,
	input  wire  logic        [7:0]  conv_len,
	input  wire  logic        [1:0]  fault_mode,
	// engine side towards the block
	output logic                     conv_busy,
	output logic                     remote_valid,
	output logic signed       [12:0] remote_temp,
	output logic                     diode_fault_pin,
	output logic                     diode_short_pin
);
	int   i;  // cycle index inside one conversion
	logic go; // start command as seen on the edge

	// ----------------------------------------------------------------
	// conversion sequence
	// ----------------------------------------------------------------
	// fault_mode: 0 clean, 1 open pulse mid-conversion, 2 shorted diode
	initial
	begin
		conv_busy       = 1'b0;
		remote_valid    = 1'b0;
		remote_temp     = 13'h0AAA;
		diode_fault_pin = 1'b0;
		diode_short_pin = 1'b0;
		forever
		begin
			@(posedge clk);
			// command taken on the edge, the bench moves it 1 ns later,
			// so reading it there cannot race the bench
			go = start && nrst;
			#1;
			remote_valid    = 1'b0;
			diode_short_pin = 1'b0;
			// sample bus is not valid here, so it keeps toggling
			remote_temp     = ~remote_temp;
			if (go)
			begin
				conv_busy       = 1'b1;
				diode_short_pin = (fault_mode == 2'h2);
				for (i = 0; i < conv_len; i++)
				begin
					@(posedge clk);
					#1;
					remote_temp     = ~remote_temp;
					// pulse ends well before the end of the conversion
					diode_fault_pin = (fault_mode == 2'h1)
						&& (i == 2 || i == 3);
				end
				remote_valid = 1'b1;
				remote_temp  = temp_in;
				@(posedge clk);
				#1;
				remote_valid = 1'b0;
				conv_busy    = 1'b0;
				remote_temp  = ~temp_in;
			end
		end
	end
endmodule : rtrf_diode_model

// *** verification/rtrf_top_tb.sv ***
// self-checking bench for the remote temperature result filter
`timescale 1ns/1ps
module rtrf_top_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic               clk, nrst;          // clock and reset
	logic               reg_wr_en, reg_rd_en; // register strobes
	logic        [7:0]  reg_addr, reg_wdata;  // register address, data
	logic        [7:0]  reg_rdata;            // register read data
	logic               range_ext, conv_busy; // range and busy level
	logic               local_valid, remote_valid;
	logic signed [12:0] local_temp, remote_temp;
	logic               diode_fault_pin, diode_short_pin;
	logic        [7:0]  overtemp_limit;       // trip threshold
	logic               diode_open_flag, overtemp_trip_output;
	logic               start;                // model command
	logic signed [12:0] temp_in;
	logic        [7:0]  conv_len;
	logic        [1:0]  fault_mode;
	int                 failures, n_checks, cycles;

	rtrf_top rtrf_top_inst (.clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .range_ext(range_ext), .conv_busy(conv_busy),
		.local_valid(local_valid), .local_temp(local_temp),
		.remote_valid(remote_valid), .remote_temp(remote_temp),
		.diode_fault_pin(diode_fault_pin), .diode_short_pin(diode_short_pin),
		.overtemp_limit(overtemp_limit), .diode_open_flag(diode_open_flag),
		.overtemp_trip_output(overtemp_trip_output));

	rtrf_diode_model rtrf_diode_model_inst (.clk(clk), .nrst(nrst),
		.start(start), .temp_in(temp_in), .conv_len(conv_len),
		.fault_mode(fault_mode), .conv_busy(conv_busy),
		.remote_valid(remote_valid), .remote_temp(remote_temp),
		.diode_fault_pin(diode_fault_pin),
		.diode_short_pin(diode_short_pin));

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// whole run needs a few hundred cycles, so 20000 means a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// every task starts and ends just after a rising edge
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge clk);
		#1;
		reg_wr_en = 1'b0;
		@(posedge clk);
		#1;
	endtask : reg_wr

	// read data lands on the edge that takes the strobe
	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		reg_addr  = a;
		reg_rd_en = 1'b1;
		@(posedge clk);
		#1;
		reg_rd_en = 1'b0;
		check(what, reg_rdata, exp);
		@(posedge clk);
		#1;
	endtask : rd_chk

	// one remote conversion; results settle two edges after the strobe
	task automatic conv(input logic signed [12:0] t, input logic [1:0] fm,
		input logic [7:0] len);
		int k;
		temp_in    = t;
		fault_mode = fm;
		conv_len   = len;
		start      = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		k     = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (remote_valid !== 1'b1 && k < 200);
		if (k >= 200)
			check("conversion strobe", 8'h00, 8'h01);
		repeat (3) @(posedge clk);
		#1;
	endtask : conv

	task automatic rem_chk(input logic [7:0] hi, input logic [7:0] lo);
		rd_chk("remote high byte", rtrf_pkg::ADDR_REMOTE_HI, hi);
		rd_chk("remote low byte", rtrf_pkg::ADDR_REMOTE_LO, lo);
	endtask : rem_chk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk("filter control", rtrf_pkg::ADDR_FILT_CTRL, 8'h00);
		rd_chk("unmapped", 8'h3F, 8'h00);
		reg_wr(rtrf_pkg::ADDR_REMOTE_HI, 8'h55); // result is read-only
		rd_chk("remote high byte", rtrf_pkg::ADDR_REMOTE_HI, 8'h00);
		check("open flag", {7'h00, diode_open_flag}, 8'h00);
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, 8'h07);
		rd_chk("filter control", rtrf_pkg::ADDR_FILT_CTRL, 8'h07);
		conv(13'sh0A0, 2'h0, 8'h08); // unknown codes act as bypass
		rem_chk(8'h0A, 8'h00);
	endtask : t_reset

	task automatic fmt(input logic ext, input logic signed [12:0] t,
		input logic [7:0] hi, input logic [7:0] lo);
		range_ext = ext;
		conv(t, 2'h0, 8'h08);
		rem_chk(hi, lo);
	endtask : fmt

	task automatic t_format();
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, 8'h00);
		fmt(1'b0, 13'sh0147, 8'h14, 8'h70);
		fmt(1'b0, 13'sh1EC0, 8'hEC, 8'h00);
		fmt(1'b0, 13'sh1FFF, 8'hFF, 8'hF0);
		fmt(1'b0, 13'sh0960, 8'h7F, 8'hF0);
		fmt(1'b1, 13'sh0960, 8'hD6, 8'h00);
		fmt(1'b1, 13'sh1C00, 8'h00, 8'h00);
		range_ext = 1'b0;
	endtask : t_format

	// step from 0 to 10 degrees seen through each filter setting
	task automatic t_filter();
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, rtrf_pkg::FILT_AVG4);
		conv(13'sh0000, 2'h0, 8'h08);
		conv(13'sh00A0, 2'h0, 8'h14);
		rem_chk(8'h02, 8'h80);
		// local channel stays raw while averaging is on
		local_temp  = 13'sh0000;
		local_valid = 1'b1;
		@(posedge clk);
		#1;
		local_temp = 13'sh00A0;
		@(posedge clk);
		#1;
		local_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rd_chk("local high byte", rtrf_pkg::ADDR_LOCAL_HI, 8'h0A);
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, rtrf_pkg::FILT_AVG8);
		conv(13'sh0000, 2'h0, 8'h08);
		conv(13'sh00A0, 2'h0, 8'h08);
		rem_chk(8'h01, 8'h40);
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, rtrf_pkg::FILT_OFF);
		conv(13'sh0000, 2'h0, 8'h08);
		conv(13'sh00A0, 2'h0, 8'h08);
		rem_chk(8'h0A, 8'h00);
	endtask : t_filter

	// limit 5: filtered 2.5 and 5.0 stay quiet, 7.5 trips
	task automatic t_trip();
		overtemp_limit = 8'h05;
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, rtrf_pkg::FILT_AVG4);
		conv(13'sh0000, 2'h0, 8'h08);
		conv(13'sh00A0, 2'h0, 8'h08);
		check("trip at 2.5", {7'h00, overtemp_trip_output}, 8'h00);
		conv(13'sh00A0, 2'h0, 8'h08);
		check("trip at 5.0", {7'h00, overtemp_trip_output}, 8'h00);
		conv(13'sh00A0, 2'h0, 8'h08);
		check("trip at 7.5", {7'h00, overtemp_trip_output}, 8'h01);
		reg_wr(rtrf_pkg::ADDR_FILT_CTRL, rtrf_pkg::FILT_OFF);
	endtask : t_trip

	task automatic t_fault();
		conv(13'sh00A0, 2'h2, 8'h08);
		rem_chk(8'hC0, 8'h00);
		// pulse gone long before the strobe, slow conversion
		conv(13'sh00A0, 2'h1, 8'h1E);
		check("open flag", {7'h00, diode_open_flag}, 8'h01);
		reg_addr  = rtrf_pkg::ADDR_STATUS;
		reg_rd_en = 1'b1;
		@(posedge clk);
		#1;
		reg_rd_en = 1'b0;
		check("status open bit", reg_rdata & 8'h04, 8'h04);
		@(posedge clk);
		#1;
		conv(13'sh00A0, 2'h0, 8'h08);
		check("open flag clean", {7'h00, diode_open_flag}, 8'h00);
	endtask : t_fault

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst           = 1'b0;
		reg_wr_en      = 1'b0;
		reg_rd_en      = 1'b0;
		reg_addr       = 8'h00;
		reg_wdata      = 8'h00;
		range_ext      = 1'b0;
		local_valid    = 1'b0;
		local_temp     = 13'sh0000;
		overtemp_limit = 8'h7F;
		start          = 1'b0;
		temp_in        = 13'sh0000;
		conv_len       = 8'h08;
		fault_mode     = 2'h0;
		failures       = 0;
		n_checks       = 0;
		cycles         = 0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_reset();
		t_format();
		t_filter();
		t_trip();
		t_fault();
		end_sim();
	end
endmodule : rtrf_top_tb
